// ===== logic/ssac_pkg.sv
// Types of the serial step angle control block.
// Assumes ssac_regs.svh is on the include path.
`include "ssac_regs.svh"

package ssac_pkg;

    // ------------------------------------------------------------
    // State of the phase table memory
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0][5:0] mem;
        logic [5:0] rd_a;
        logic [5:0] rd_b;
    } ssac_mem_t;

    // ------------------------------------------------------------
    // State of the step control top
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sck_sy;
        logic [1:0] sdi_sy;
        logic [2:0] stb_sy;
        logic [15:0] shift;
        logic [4:0] nbits;
        logic [5:0] angle;
        logic [3:0] ld_ptr;
        logic [7:0] cfg;
        logic step;
        logic custom;
        logic a_zero1;
        logic b_zero1;
        logic a_neg1;
        logic b_neg1;
        logic [5:0] a_code;
        logic [5:0] b_code;
        logic a_neg;
        logic b_neg;
    } ssac_top_t;

endpackage

// ===== logic/ssac_regs.svh
// Constants of the serial step angle control block: frame layout,
// register selectors and table defaults.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SSAC_REGS_SVH
`define SSAC_REGS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SSAC_FRAME_BITS 5'h10
// Bit counter saturates so a long frame never wraps back to a legal count
`define SSAC_NBITS_MAX 5'h1f
`define SSAC_ADDR_HI 15
`define SSAC_ADDR_LO 14
`define SSAC_CFG_HI 13
`define SSAC_CFG_LO 6
`define SSAC_SC_HI 5
`define SSAC_SC_LO 0
`define SSAC_ADDR_RUN 2'h2
`define SSAC_ADDR_TBL 2'h3

// ----------------------------------------------------------------
// Phase table geometry
// ----------------------------------------------------------------
`define SSAC_QUAD_SPAN 5'h10
`define SSAC_PHASE_OFS 6'h10
`define SSAC_ZERO_CODE 6'h00
// Entries 1..16 of the 17-value quarter wave; entry 0 is always zero
`define SSAC_TBL_DEFAULT {6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30, \
    6'h2c, 6'h28, 6'h23, 6'h1d, 6'h17, 6'h12, 6'h0b, 6'h05}

`endif

// ===== logic/ssac_step_ctrl.sv
// Step angle control: serial frame receiver, modulo-64 step angle
// register and symmetric phase current lookup.
// Assumes the serial pins come from another domain; the core clock
// is far faster than the serial clock.
//
// Function
// [RL1] Step angle stays 0..63, modulo 64
// [RL2] Increment past 63 wraps to bottom
// [RL3] Decrement below 0 wraps to top
// [RL4] Step change field is bits 0..5
// [RL5] Field is signed, added to angle
// [RL6] One unit equals one sixteenth microstep
// [RL7] Host uses 16/8/4/2 per step size
// [RL8] Host repeats 000100 forward, 111100 reverse
// [RL9] Host resends other run bits each time
// [RL10] Step applied only on strobe rising edge
// [RL11] Serial clock never causes a step
// [RL12] Everything but sleep controllable serially
// [RL13] One 6-bit code per phase per position
// [RL14] Table derived from 17 symmetric values
// [RL15] Programmed profile replaces default sinusoid
// [RL16] Entry zero fixed; 16 loaded sequentially
// [RL17] Phase current is 6-bit converter code
// [RL18] Step angle clears to zero on reset
`timescale 1ns/1ps
`include "ssac_regs.svh"

module ssac_step_ctrl import ssac_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_serial_strobe_low,
    output logic [5:0] o_step_angle,
    output logic [5:0] o_phase_a_code,
    output logic [5:0] o_phase_b_code,
    output logic o_phase_a_neg,
    output logic o_phase_b_neg,
    output logic o_step_pulse,
    output logic o_table_custom,
    output logic [7:0] o_run_cfg
);

    ssac_top_t r_ff;
    ssac_top_t nxt_r;

    // Strobe sync starts at its idle level, so leaving reset shows no false edge
    localparam ssac_top_t RST_STATE = '{stb_sy: '1, default: '0};

    logic sck_rise;
    logic stb_rise;
    logic stb_low;
    logic frame_ok;
    logic run_evt;
    logic tbl_evt;
    logic [5:0] sc_field;
    logic [5:0] b_pos;
    logic [4:0] a_idx;
    logic [4:0] b_idx;
    logic [3:0] a_raddr;
    logic [3:0] b_raddr;
    logic [5:0] a_rdata;
    logic [5:0] b_rdata;

    // ------------------------------------------------------------
    // Pin edges and frame decode
    // ------------------------------------------------------------
    // Edges look only at the second and third sync stages
    assign sck_rise = r_ff.sck_sy[1] & ~r_ff.sck_sy[2];
    assign stb_rise = r_ff.stb_sy[1] & ~r_ff.stb_sy[2];
    assign stb_low = ~r_ff.stb_sy[1];
    // Short or long frames are dropped rather than half applied
    assign frame_ok = (r_ff.nbits == `SSAC_FRAME_BITS);
    assign run_evt = stb_rise && frame_ok &&
        (r_ff.shift[`SSAC_ADDR_HI:`SSAC_ADDR_LO] == `SSAC_ADDR_RUN); // [RL10] [RL12]
    assign tbl_evt = stb_rise && frame_ok &&
        (r_ff.shift[`SSAC_ADDR_HI:`SSAC_ADDR_LO] == `SSAC_ADDR_TBL); // [RL12] [RL16]
    assign sc_field = r_ff.shift[`SSAC_SC_HI:`SSAC_SC_LO]; // [RL4]

    // ------------------------------------------------------------
    // Quadrant symmetry index
    // ------------------------------------------------------------
    // Odd quadrants mirror the quarter wave; phase B leads A by 16
    assign b_pos = r_ff.angle + `SSAC_PHASE_OFS; // [RL14]
    assign a_idx = r_ff.angle[4] ? 5'(`SSAC_QUAD_SPAN - {1'b0, r_ff.angle[3:0]})
                                 : {1'b0, r_ff.angle[3:0]}; // [RL14]
    assign b_idx = b_pos[4] ? 5'(`SSAC_QUAD_SPAN - {1'b0, b_pos[3:0]})
                            : {1'b0, b_pos[3:0]}; // [RL14]
    assign a_raddr = 4'(a_idx - 5'h01);
    assign b_raddr = 4'(b_idx - 5'h01);

    ssac_tbl_mem u_tbl (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_we(tbl_evt),
        .i_waddr(r_ff.ld_ptr),
        .i_wdata(sc_field),
        .i_raddr_a(a_raddr),
        .i_raddr_b(b_raddr),
        .o_rdata_a(a_rdata),
        .o_rdata_b(b_rdata)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        nxt_r.sck_sy = {r_ff.sck_sy[1:0], i_sck};
        nxt_r.sdi_sy = {r_ff.sdi_sy[0], i_sdi};
        nxt_r.stb_sy = {r_ff.stb_sy[1:0], i_serial_strobe_low};
        nxt_r.step = 1'b0;
        // Serial clock only shifts bits, it never moves the angle
        if (sck_rise && stb_low) begin
            nxt_r.shift = {r_ff.shift[14:0], r_ff.sdi_sy[1]}; // [RL11]
            if (r_ff.nbits != `SSAC_NBITS_MAX) begin
                nxt_r.nbits = r_ff.nbits + 5'h01;
            end
        end
        if (stb_rise) begin
            nxt_r.nbits = 5'h00;
        end
        if (run_evt) begin
            // Six-bit sum wraps both ways; unit is a sixteenth microstep
            nxt_r.angle = r_ff.angle + sc_field; // [RL1] [RL2] [RL3] [RL5] [RL6]
            nxt_r.cfg = r_ff.shift[`SSAC_CFG_HI:`SSAC_CFG_LO]; // [RL12]
            nxt_r.step = 1'b1; // [RL10]
        end
        if (tbl_evt) begin
            nxt_r.ld_ptr = r_ff.ld_ptr + 4'h1; // [RL16]
            nxt_r.custom = 1'b1; // [RL15]
        end
        // Two-stage lookup: memory read, then output register
        nxt_r.a_zero1 = (a_idx == 5'h00); // [RL16]
        nxt_r.b_zero1 = (b_idx == 5'h00); // [RL16]
        nxt_r.a_neg1 = r_ff.angle[5] && (a_idx != 5'h00);
        nxt_r.b_neg1 = b_pos[5] && (b_idx != 5'h00);
        nxt_r.a_code = r_ff.a_zero1 ? `SSAC_ZERO_CODE : a_rdata; // [RL13] [RL17]
        nxt_r.b_code = r_ff.b_zero1 ? `SSAC_ZERO_CODE : b_rdata; // [RL13] [RL17]
        nxt_r.a_neg = r_ff.a_neg1;
        nxt_r.b_neg = r_ff.b_neg1;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            r_ff <= RST_STATE; // [RL18]
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_step_angle = r_ff.angle;
    assign o_phase_a_code = r_ff.a_code;
    assign o_phase_b_code = r_ff.b_code;
    assign o_phase_a_neg = r_ff.a_neg;
    assign o_phase_b_neg = r_ff.b_neg;
    assign o_step_pulse = r_ff.step;
    assign o_table_custom = r_ff.custom;
    assign o_run_cfg = r_ff.cfg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_add_mod;
        run_evt |=> (r_ff.angle == 6'($past(r_ff.angle) + $past(sc_field)));
    endproperty
    a_add_mod: assert property (p_add_mod) else $error("angle sum wrong"); // [RL5]

    property p_wrap_up;
        (run_evt && r_ff.angle == 6'h3f && sc_field == 6'h02) |=> r_ff.angle == 6'h01;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("upward wrap wrong"); // [RL2]

    property p_wrap_dn;
        (run_evt && r_ff.angle == 6'h00 && sc_field == 6'h3e) |=> r_ff.angle == 6'h3e;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("downward wrap wrong"); // [RL3]

    property p_hold;
        !run_evt |=> $stable(r_ff.angle);
    endproperty
    a_hold: assert property (p_hold) else $error("angle moved without strobe"); // [RL10]

    property p_sck_no_step;
        (sck_rise && !stb_rise) |=> !o_step_pulse;
    endproperty
    a_sck_no_step: assert property (p_sck_no_step) else $error("step from clock"); // [RL11]

    property p_pulse;
        run_evt |=> o_step_pulse ##1 !o_step_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("step pulse shape wrong"); // [RL10]

    property p_reset_zero;
        $rose(i_rst_n) |-> o_step_angle == 6'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("angle not cleared"); // [RL18]

    property p_zero_entry;
        (o_step_angle == 6'h10 && !run_evt) [*3] |-> o_phase_b_code == 6'h00;
    endproperty
    a_zero_entry: assert property (p_zero_entry) else $error("entry zero not zero"); // [RL16]

    property p_load_ptr;
        tbl_evt |=> r_ff.ld_ptr == 4'($past(r_ff.ld_ptr) + 4'h1) && o_table_custom;
    endproperty
    a_load_ptr: assert property (p_load_ptr) else $error("table load skipped"); // [RL15]

    property p_mirror;
        (o_step_angle == 6'h11 && !run_evt && !tbl_evt) [*3] |->
            o_phase_a_code == u_tbl.r_ff.mem[4'he];
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror lookup wrong"); // [RL14]

    c_fwd: cover property (run_evt && sc_field == 6'h04);
    c_rev: cover property (run_evt && sc_field == 6'h3c);
    c_wrap: cover property (run_evt && r_ff.angle == 6'h3f && sc_field == 6'h01);
    c_load: cover property (tbl_evt ##[1:1000] run_evt);

endmodule

// ===== logic/ssac_tbl_mem.sv
// Programmable phase table: 16 writable 6-bit entries, two read ports.
// Assumes one write per cycle at most; read data come one cycle after address.
`timescale 1ns/1ps
`include "ssac_regs.svh"

module ssac_tbl_mem import ssac_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [5:0] i_wdata,
    input wire logic [3:0] i_raddr_a,
    input wire logic [3:0] i_raddr_b,
    output logic [5:0] o_rdata_a,
    output logic [5:0] o_rdata_b
);

    ssac_mem_t r_ff;
    ssac_mem_t nxt_r;

    // ------------------------------------------------------------
    // Storage and registered reads
    // ------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        // Reads see old contents on a same-cycle write
        nxt_r.rd_a = r_ff.mem[i_raddr_a];
        nxt_r.rd_b = r_ff.mem[i_raddr_b];
        if (i_we) begin
            nxt_r.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            r_ff.mem <= `SSAC_TBL_DEFAULT;
            r_ff.rd_a <= `SSAC_ZERO_CODE;
            r_ff.rd_b <= `SSAC_ZERO_CODE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_rdata_a = r_ff.rd_a;
    assign o_rdata_b = r_ff.rd_b;

endmodule

// ===== tb/ssac_host_model.sv
// Host model: drives the three serial pins of the step control block.
// Assumes the core clock is given; pins change at its falling edge.
`timescale 1ns/1ps

module ssac_host_model (
    input wire logic i_core_clk,
    output logic o_sck,
    output logic o_sdi,
    output logic o_serial_strobe_low
);
    // 4 low plus 4 high core cycles give the 200 ns link clock
    localparam int HALF_CYC = 4;

    initial begin
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_serial_strobe_low = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // Bits MSB first; framed low only when asked, so stray clocks can be sent
    task automatic send(input logic [15:0] word, input int nbits, input logic framed);
        @(negedge i_core_clk);
        if (framed) begin
            o_serial_strobe_low = 1'b0;
        end
        hold(HALF_CYC);
        for (int k = nbits - 1; k >= 0; k--) begin
            o_sdi = word[k];
            hold(HALF_CYC);
            o_sck = 1'b1;
            hold(HALF_CYC);
            o_sck = 1'b0;
        end
        hold(HALF_CYC);
        o_serial_strobe_low = 1'b1; // Rising edge ends the write
        o_sdi = ~o_sdi; // Released line must not keep its last value
    endtask
endmodule

// ===== tb/ssac_step_ctrl_tb.sv
// Testbench of the step control block with a host model on the pins.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps

module ssac_step_ctrl_tb;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    wire sck, sdi, stb_n;
    logic [5:0] angle, a_code, b_code, cur;
    logic a_neg, b_neg, pulse, custom;
    logic [7:0] cfg;
    int mismatches = 0;
    int total_checks = 0;
    int pulses = 0;
    logic [5:0] tbl_def [1:16] = '{6'h05, 6'h0b, 6'h12, 6'h17, 6'h1d, 6'h23, 6'h28, 6'h2c,
        6'h30, 6'h34, 6'h37, 6'h3a, 6'h3c, 6'h3e, 6'h3f, 6'h3f};
    logic [5:0] tbl [1:16];

    ssac_host_model i_host (.i_core_clk(i_core_clk), .o_sck(sck), .o_sdi(sdi),
        .o_serial_strobe_low(stb_n));

    ssac_step_ctrl i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sck(sck),
        .i_sdi(sdi), .i_serial_strobe_low(stb_n), .o_step_angle(angle),
        .o_phase_a_code(a_code), .o_phase_b_code(b_code), .o_phase_a_neg(a_neg),
        .o_phase_b_neg(b_neg), .o_step_pulse(pulse), .o_table_custom(custom),
        .o_run_cfg(cfg));

    initial forever #12.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) if (pulse === 1'b1) pulses++;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge i_core_clk);
        #1;
    endtask

    // Sign and magnitude of one phase, from quarter-wave symmetry
    function automatic logic [6:0] phase(input logic [5:0] ang);
        logic [4:0] idx;
        idx = ang[4] ? 5'h10 - {1'b0, ang[3:0]} : {1'b0, ang[3:0]};
        return (idx == 5'h00) ? 7'h00 : {ang[5], tbl[idx]};
    endfunction

    task automatic wait_pulse();
        int n;
        n = 0;
        while (pulse !== 1'b1) begin
            tick();
            n++;
            if (n > 40) begin
                mismatches++;
                $display("BAD step_pulse expected 1 seen 0");
                results();
            end
        end
    endtask

    task automatic run_step(input logic [5:0] sc, input logic [7:0] cfgv);
        logic [5:0] exp_ang;
        exp_ang = cur + sc; // Six-bit sum wraps modulo 64
        i_host.send({2'h2, cfgv, sc}, 16, 1'b1); // Config resent each time
        wait_pulse();
        check("angle", {10'h0, angle}, {10'h0, exp_ang});
        check("run_cfg", {8'h0, cfg}, {8'h0, cfgv});
        tick();
        check("pulse_width", {15'h0, pulse}, 16'h0);
        tick();
        check("phase_a", {9'h0, a_neg, a_code}, {9'h0, phase(exp_ang)});
        check("phase_b", {9'h0, b_neg, b_code}, {9'h0, phase(exp_ang + 6'h10)});
        cur = exp_ang;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("angle", {10'h0, angle}, 16'h0);
        check("custom", {15'h0, custom}, 16'h0);
        check("phase_b", {9'h0, b_neg, b_code}, {9'h0, phase(6'h10)});
        cur = 6'h00;
        $display("reset test done");
    endtask

    task automatic t_wrap();
        logic [5:0] sc [6] = '{6'h3e, 6'h01, 6'h02, 6'h3f, 6'h3f, 6'h01};
        foreach (sc[k]) run_step(sc[k], 8'h5a);
        $display("wrap test done");
    endtask

    task automatic t_sizes();
        logic [5:0] sc [9] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h3c, 6'h3c, 6'h3c, 6'h04,
            6'h04};
        foreach (sc[k]) run_step(sc[k], 8'ha5 ^ 8'(k));
        $display("step size test done");
    endtask

    task automatic t_refused();
        int p0;
        p0 = pulses;
        i_host.send(16'h8001, 15, 1'b1); // Short frame, dropped
        repeat (12) tick();
        i_host.send(16'h0001, 16, 1'b1); // Unused address, dropped
        repeat (12) tick();
        i_host.send(16'h8001, 16, 1'b0); // Serial clock with strobe idle
        repeat (12) tick();
        check("pulse_count", 16'(pulses - p0), 16'h0);
        check("angle", {10'h0, angle}, {10'h0, cur});
        run_step(6'h01, 8'h00);
        $display("refused frame test done");
    endtask

    task automatic t_table();
        int p0;
        p0 = pulses;
        for (int k = 1; k <= 16; k++) begin
            tbl[k] = 6'(k * 3); // Ramp differs from the sinusoid everywhere
            i_host.send({2'h3, 8'h00, tbl[k]}, 16, 1'b1);
            repeat (8) tick();
        end
        check("custom", {15'h0, custom}, 16'h1);
        check("pulse_count", 16'(pulses - p0), 16'h0);
        run_step(6'h36, 8'h11); // Back 10 to angle 17, a mirrored spot
        run_step(6'h20, 8'h22);
        $display("table load test done");
    endtask

    task automatic t_mid_reset();
        @(negedge i_core_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        tbl = tbl_def; // Reset brings back the default sinusoid
        repeat (4) tick();
        t_reset();
        run_step(6'h11, 8'h3c);
        $display("mid-run reset test done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        tbl = tbl_def;
        repeat (8) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst_n = 1'b1;
        repeat (4) tick();
        t_reset();
        t_wrap();
        t_sizes();
        t_refused();
        t_table();
        t_mid_reset();
        results();
    end

    // Hang guard: far beyond the longest sequence
    initial begin
        repeat (50000) @(posedge i_core_clk);
        mismatches++;
        results();
    end
endmodule
